// file: src/iic_defs.svh
`ifndef IIC_DEFS_SVH
`define IIC_DEFS_SVH

// apb register byte offsets
`define IIC_OFF_LEVEL_REQ    8'h00
`define IIC_OFF_LEVEL_EN     8'h04
`define IIC_OFF_CUR_LEVEL    8'h08
`define IIC_OFF_SRC_MASK     8'h0C
`define IIC_OFF_CAUSE        8'h10
`define IIC_OFF_FAULT_STAT   8'h14
`define IIC_OFF_FAULT_ADDR   8'h18
`define IIC_OFF_CTRL         8'h1C
`define IIC_OFF_ERR_IND      8'h20

// control register fields
`define IIC_CTRL_PAGING_BIT  0
`define IIC_CTRL_INTSYS_BIT  1
`define IIC_CTRL_CLOCK_BIT   2
`define IIC_CTRL_FAULTLK_BIT 3

// internal cause codes (octal in the cpu's own notation)
`define IIC_CODE_NONE        4'h0
`define IIC_CODE_MON_CALL    4'h1
`define IIC_CODE_PROTECT     4'h2
`define IIC_CODE_PAGE_FAULT  4'h3
`define IIC_CODE_ILLEGAL     4'h4
`define IIC_CODE_ERR_IND     4'h5
`define IIC_CODE_PRIV        4'h6
`define IIC_CODE_IO_TIMEOUT  4'h7
`define IIC_CODE_PARITY      4'h8
`define IIC_CODE_OUT_RANGE   4'h9
`define IIC_CODE_SUPPLY      4'hA

// error indicator position in the status word
`define IIC_STS_ERR_BIT      3
// level forced by any internal interrupt
`define IIC_INTERNAL_LEVEL   4'hE
// rings below this count as user rings for privilege checks
`define IIC_PRIV_RING        2'h2

// reset values
`define IIC_RST_WORD16       16'h0000
`define IIC_RST_LEVEL        4'h0

// timing
`define IIC_CLK_PERIOD_NS    50
`define IIC_IO_TIMEOUT_NS    6000
`define IIC_IO_TIMEOUT_CYC   (`IIC_IO_TIMEOUT_NS / `IIC_CLK_PERIOD_NS)

`endif

// file: src/iic_pkg.sv
package iic_pkg;
	typedef logic [3:0]  iic_code_t;
	typedef logic [3:0]  iic_level_t;
	typedef logic [15:0] iic_word_t;
endpackage

// file: src/iic_cause_if.sv
`timescale 1ns/1ns
interface iic_cause_if;
	iic_pkg::iic_word_t src;
	logic               valid;
	iic_pkg::iic_code_t code;

	modport sel  (input src, output valid, output code);
	modport user (output src, input valid, input code);
endinterface

// file: src/iic_cause_sel.sv
`timescale 1ns/1ns
`include "iic_defs.svh"
module iic_cause_sel (
	iic_cause_if.sel cif // pending cause vector in, chosen code out
);
	// only one source is expected at a time; supply loss outranks any coincidence
	always_comb begin
		cif.valid = |cif.src;
		cif.code  = `IIC_CODE_NONE;
		if (cif.src[`IIC_CODE_SUPPLY]) begin
			cif.code = `IIC_CODE_SUPPLY;
		end else begin
			for (int i = 15; i >= 1; i--) begin
				if (cif.src[i]) begin
					cif.code = 4'(i);
				end
			end
		end
	end
endmodule

// file: src/iic_ctrl.sv
// Contract
// - cause 5 while error indicator set
// - error interrupt recurs until level 14 clears
// - cause 6 on privileged instruction in rings 0-1
// - cause 7 when i/o answer misses 6 us
// - cause 10: parity, capture fault address/status
// - cause 11: out of range, capture fault info
// - cause 12 supply loss wins coincidences
// - source mask gates every internal interrupt
// - protect, page fault, privileged need paging on
// - abort class mid-instruction, others at completion
// - fetch-cycle faults keep program counter unchanged
// - power-up clears request, enable, level registers
// - error indicator is status bit 3 per level; the code keeps one err_ind_r bit per level instead
// - cause/fault registers locked; reads unlock them
// - level enable mask gates level activation
// - interrupt-on resumes highest pending enabled level
// - interrupt-on privileged, lights panel indicator
// - internal interrupt forces level 14, locks cause
// - interrupt-off freezes level, darkens panel, privileged
`timescale 1ns/1ns
`include "iic_defs.svh"
module iic_ctrl #(
	parameter int IO_TIMEOUT_CYC = `IIC_IO_TIMEOUT_CYC
) (
	input  wire logic        CORE_CLK_I,          // cpu clock, 20 MHz
	input  wire logic        RESET_N_I,           // async power-up reset
	input  wire logic        PSEL_I,              // apb select
	input  wire logic        PENABLE_I,           // apb enable
	input  wire logic        PWRITE_I,            // apb write
	input  wire logic [7:0]  PADDR_I,             // apb byte address
	input  wire logic [31:0] PWDATA_I,            // apb write data
	output logic      [31:0] PRDATA_O,            // apb read data
	output logic             PREADY_O,            // apb ready
	output logic             PSLVERR_O,           // apb error, unmapped
	input  wire logic        INSTR_DONE_I,        // machine instruction completes
	input  wire logic        FETCH_CYCLE_I,       // next_instr_read or fetch cycle
	input  wire logic [1:0]  RING_I,              // ring of running code
	input  wire logic        PRIV_INSTR_I,        // other privileged instruction
	input  wire logic        ION_INSTR_I,         // interrupt-on instruction
	input  wire logic        IOF_INSTR_I,         // intsys_off instruction
	input  wire logic        MONITOR_CALL_I,      // monitor_call executed
	input  wire logic        PROTECT_VIOLATION_I, // protect_violation detected
	input  wire logic        PAGE_FAULT_I,        // page_fault detected
	input  wire logic        ILLEGAL_INSTR_I,     // illegal_instruction detected
	input  wire logic        FLOAT_DIVIDE_ZERO_I, // float_divide by zero
	input  wire logic        EXECUTE_REG_NEST_I,  // execute_reg of execute_reg
	input  wire logic        NORMALIZE_OP_OVF_I,  // normalize_op overflow
	input  wire logic        REG_DIVIDE_OVF_I,    // reg_divide overflow
	input  wire logic        IO_TRANSFER_START_I, // identify or io_transfer starts
	input  wire logic        IO_CONNECT_I,        // device response pin
	input  wire logic        PARITY_ERROR_I,      // memory parity_error
	input  wire logic        OUT_OF_RANGE_I,      // out_of_range access
	input  wire logic [17:0] FAULT_ADDR_I,        // address of failing access
	input  wire logic [13:0] FAULT_INFO_I,        // error details of failing access
	input  wire logic        SUPPLY_LOSS_I,       // power sense pin
	output logic             ABORT_O,             // abort microprogram now
	output logic             PC_HOLD_O,           // do not advance program counter
	output logic             LEVEL_CHANGE_O,      // level switch this cycle
	output logic      [3:0]  ACTIVE_LEVEL_O,      // current_level, register set
	output logic             PANEL_INT_O          // panel interrupt indicator
);
	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [4:0] top_level(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] onehot(input logic [3:0] n);
		return 16'h0001 << n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic conn_s1_r, conn_s2_r, supply_s1_r, supply_s2_r;

	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			conn_s1_r   <= 1'b0;
			conn_s2_r   <= 1'b0;
			supply_s1_r <= 1'b0;
			supply_s2_r <= 1'b0;
		end else begin
			conn_s1_r   <= IO_CONNECT_I;
			conn_s2_r   <= conn_s1_r;
			supply_s1_r <= SUPPLY_LOSS_I;
			supply_s2_r <= supply_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb slave decode

	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic        acc, wr, rd, hit;
	iic_pkg::iic_word_t level_req_r, level_req_nxt, level_en_r, level_en_nxt;
	iic_pkg::iic_word_t src_mask_r, src_mask_nxt, err_ind_r, err_ind_nxt;
	iic_pkg::iic_word_t fault_addr_r, fault_addr_nxt, fault_stat_r, fault_stat_nxt;
	iic_pkg::iic_word_t pending_r, pending_nxt;
	iic_pkg::iic_level_t level_r, level_nxt;
	iic_pkg::iic_code_t  cause_r, cause_nxt;
	logic paging_r, paging_nxt, intsys_r, intsys_nxt;
	logic cause_lk_r, cause_lk_nxt, fault_lk_r, fault_lk_nxt;
	logic pc_hold_pend_r, pc_hold_pend_nxt;
	logic abort_r, abort_nxt, pc_hold_r, pc_hold_nxt, lvl_chg_r, lvl_chg_nxt;
	logic [7:0] io_cnt_r, io_cnt_nxt;
	logic io_wait_r, io_wait_nxt;

	assign acc = PSEL_I && PENABLE_I && pready_r;
	assign wr  = acc && PWRITE_I;
	assign rd  = acc && !PWRITE_I;

	always_comb begin
		hit = 1'b1;
		case (PADDR_I)
			`IIC_OFF_LEVEL_REQ:  prdata_nxt = {16'h0000, level_req_r};
			`IIC_OFF_LEVEL_EN:   prdata_nxt = {16'h0000, level_en_r};
			`IIC_OFF_CUR_LEVEL:  prdata_nxt = {28'h000_0000, level_r};
			`IIC_OFF_SRC_MASK:   prdata_nxt = {16'h0000, src_mask_r};
			`IIC_OFF_CAUSE:      prdata_nxt = {28'h000_0000, cause_r};
			`IIC_OFF_FAULT_STAT: prdata_nxt = {16'h0000, fault_stat_r};
			`IIC_OFF_FAULT_ADDR: prdata_nxt = {16'h0000, fault_addr_r};
			`IIC_OFF_CTRL:       prdata_nxt = {28'h000_0000, fault_lk_r, cause_lk_r,
			                                   intsys_r, paging_r};
			`IIC_OFF_ERR_IND:    prdata_nxt = {16'h0000, err_ind_r};
			default: begin
				prdata_nxt = 32'h0000_0000;
				hit        = 1'b0;
			end
		endcase
		// zero-wait answer: data is staged in setup, ready rises for the access phase
		pready_nxt  = PSEL_I && !PENABLE_I;
		pslverr_nxt = PSEL_I && !PENABLE_I && !hit;
		if (!(PSEL_I && !PENABLE_I)) begin
			prdata_nxt = 32'h0000_0000;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// internal sources and cause selection

	iic_cause_if cif ();
	iic_cause_sel u_sel (.cif(cif.sel));

	logic       user_ring, priv_viol, io_timeout, z_live, z_cond;
	logic [15:0] new_ev, gate, avail, abort_cls;
	logic       deliver, fetch_fault;

	assign user_ring = RING_I < `IIC_PRIV_RING;
	// interrupt on/off are privileged too; a violation suppresses their effect
	assign priv_viol = (PRIV_INSTR_I || ION_INSTR_I || IOF_INSTR_I) && user_ring;
	assign io_timeout = io_wait_r && (io_cnt_r == 8'(IO_TIMEOUT_CYC - 1)) && !conn_s2_r;
	assign z_live = err_ind_r[level_r];
	// level-sensitive: it comes back whenever a level other than 14 runs with its bit still set
	assign z_cond = z_live && (level_r != `IIC_INTERNAL_LEVEL);
	assign fetch_fault = FETCH_CYCLE_I && (OUT_OF_RANGE_I || PAGE_FAULT_I
	                     || PROTECT_VIOLATION_I);

	always_comb begin
		new_ev = 16'h0000;
		new_ev[`IIC_CODE_MON_CALL]   = MONITOR_CALL_I;
		new_ev[`IIC_CODE_PROTECT]    = PROTECT_VIOLATION_I;
		new_ev[`IIC_CODE_PAGE_FAULT] = PAGE_FAULT_I;
		new_ev[`IIC_CODE_ILLEGAL]    = ILLEGAL_INSTR_I;
		new_ev[`IIC_CODE_PRIV]       = priv_viol;
		new_ev[`IIC_CODE_IO_TIMEOUT] = io_timeout;
		new_ev[`IIC_CODE_PARITY]     = PARITY_ERROR_I;
		new_ev[`IIC_CODE_OUT_RANGE]  = OUT_OF_RANGE_I;
		new_ev[`IIC_CODE_SUPPLY]     = supply_s2_r;
		gate = src_mask_r;
		if (!paging_r) begin
			gate[`IIC_CODE_PROTECT]    = 1'b0;
			gate[`IIC_CODE_PAGE_FAULT] = 1'b0;
			gate[`IIC_CODE_PRIV]       = 1'b0;
		end
		abort_cls = onehot(`IIC_CODE_PROTECT) | onehot(`IIC_CODE_PAGE_FAULT)
		          | onehot(`IIC_CODE_ILLEGAL) | onehot(`IIC_CODE_PRIV)
		          | onehot(`IIC_CODE_IO_TIMEOUT) | onehot(`IIC_CODE_OUT_RANGE);
		avail = pending_r;
		avail[`IIC_CODE_ERR_IND] = z_cond && gate[`IIC_CODE_ERR_IND];
		// completion-class sources wait for the instruction boundary
		if (!INSTR_DONE_I) begin
			avail = avail & abort_cls;
		end
	end

	assign cif.src = avail;
	// the locked cause register holds further causes back instead of dropping them
	assign deliver = intsys_r && !cause_lk_r && cif.valid;

	////////////////////////////////////////////////////////////////////////////////
	// io response watchdog

	always_comb begin
		io_wait_nxt = io_wait_r;
		io_cnt_nxt  = io_cnt_r;
		if (IO_TRANSFER_START_I) begin
			io_wait_nxt = 1'b1;
			io_cnt_nxt  = 8'h00;
		end else if (io_wait_r) begin
			if (conn_s2_r || io_timeout) begin
				io_wait_nxt = 1'b0;
			end else begin
				io_cnt_nxt = io_cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			io_wait_r <= 1'b0;
			io_cnt_r  <= 8'h00;
		end else begin
			io_wait_r <= io_wait_nxt;
			io_cnt_r  <= io_cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt system state and registers

	logic [4:0] top;

	always_comb begin
		level_req_nxt    = level_req_r;
		level_en_nxt     = level_en_r;
		src_mask_nxt     = src_mask_r;
		err_ind_nxt      = err_ind_r;
		fault_addr_nxt   = fault_addr_r;
		fault_stat_nxt   = fault_stat_r;
		pending_nxt      = pending_r;
		level_nxt        = level_r;
		cause_nxt        = cause_r;
		paging_nxt       = paging_r;
		intsys_nxt       = intsys_r;
		cause_lk_nxt     = cause_lk_r;
		fault_lk_nxt     = fault_lk_r;
		pc_hold_pend_nxt = pc_hold_pend_r;
		abort_nxt        = 1'b0;
		pc_hold_nxt      = 1'b0;
		lvl_chg_nxt      = 1'b0;

		// software writes and read side effects first, hardware sets override below
		if (wr) begin
			case (PADDR_I)
				`IIC_OFF_LEVEL_REQ: level_req_nxt = PWDATA_I[15:0];
				`IIC_OFF_LEVEL_EN:  level_en_nxt  = PWDATA_I[15:0];
				`IIC_OFF_SRC_MASK:  src_mask_nxt  = PWDATA_I[15:0];
				`IIC_OFF_ERR_IND:   err_ind_nxt   = PWDATA_I[15:0];
				`IIC_OFF_CTRL:      paging_nxt    = PWDATA_I[`IIC_CTRL_PAGING_BIT];
				default: ;
			endcase
		end
		if (rd && PADDR_I == `IIC_OFF_CAUSE) begin
			cause_lk_nxt = 1'b0;
		end
		if (rd && PADDR_I == `IIC_OFF_FAULT_ADDR) begin
			fault_lk_nxt = 1'b0;
		end

		// error indicator sources set the running level's bit in the error indicator register
		if (FLOAT_DIVIDE_ZERO_I || EXECUTE_REG_NEST_I || NORMALIZE_OP_OVF_I
		    || REG_DIVIDE_OVF_I) begin
			err_ind_nxt[level_r] = 1'b1;
		end

		// fault capture, held until the address register is read
		if ((PARITY_ERROR_I || OUT_OF_RANGE_I) && !fault_lk_r) begin
			fault_addr_nxt = FAULT_ADDR_I[15:0];
			fault_stat_nxt = {FAULT_INFO_I, FAULT_ADDR_I[17:16]};
			fault_lk_nxt   = 1'b1;
		end

		// new gated events are sticky; set wins over delivery of an older one
		if (deliver) begin
			pending_nxt[cif.code] = 1'b0;
			if (cif.code == `IIC_CODE_ERR_IND) begin
				pending_nxt[cif.code] = 1'b0;
			end
		end
		pending_nxt = pending_nxt | (new_ev & gate);
		pending_nxt[`IIC_CODE_ERR_IND] = 1'b0;
		if (fetch_fault) begin
			pc_hold_pend_nxt = 1'b1;
		end

		if (deliver) begin
			cause_nxt    = cif.code;
			cause_lk_nxt = 1'b1;
			level_req_nxt[`IIC_INTERNAL_LEVEL] = 1'b1;
			abort_nxt    = abort_cls[cif.code];
			pc_hold_nxt  = abort_cls[cif.code] && (pc_hold_pend_r || fetch_fault)
			               && (cif.code == `IIC_CODE_OUT_RANGE
			                   || cif.code == `IIC_CODE_PAGE_FAULT
			                   || cif.code == `IIC_CODE_PROTECT);
			pc_hold_pend_nxt = 1'b0;
		end

		if (ION_INSTR_I && !user_ring) begin
			intsys_nxt = 1'b1;
		end
		if (IOF_INSTR_I && !user_ring) begin
			intsys_nxt = 1'b0;
		end

		// level switching: at boundaries, on abort delivery, or as interrupt-on retires
		top = top_level(level_req_nxt & level_en_nxt);
		if (intsys_nxt && (INSTR_DONE_I || deliver || ION_INSTR_I)) begin
			if (top[4] && top[3:0] != level_r) begin
				level_nxt   = top[3:0];
				lvl_chg_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			level_req_r    <= `IIC_RST_WORD16;
			level_en_r     <= `IIC_RST_WORD16;
			level_r        <= `IIC_RST_LEVEL;
			src_mask_r     <= `IIC_RST_WORD16;
			err_ind_r      <= `IIC_RST_WORD16;
			fault_addr_r   <= `IIC_RST_WORD16;
			fault_stat_r   <= `IIC_RST_WORD16;
			pending_r      <= `IIC_RST_WORD16;
			cause_r        <= `IIC_CODE_NONE;
			paging_r       <= 1'b0;
			intsys_r       <= 1'b0;
			cause_lk_r     <= 1'b1;
			fault_lk_r     <= 1'b1;
			pc_hold_pend_r <= 1'b0;
			abort_r        <= 1'b0;
			pc_hold_r      <= 1'b0;
			lvl_chg_r      <= 1'b0;
		end else begin
			level_req_r    <= level_req_nxt;
			level_en_r     <= level_en_nxt;
			level_r        <= level_nxt;
			src_mask_r     <= src_mask_nxt;
			err_ind_r      <= err_ind_nxt;
			fault_addr_r   <= fault_addr_nxt;
			fault_stat_r   <= fault_stat_nxt;
			pending_r      <= pending_nxt;
			cause_r        <= cause_nxt;
			paging_r       <= paging_nxt;
			intsys_r       <= intsys_nxt;
			cause_lk_r     <= cause_lk_nxt;
			fault_lk_r     <= fault_lk_nxt;
			pc_hold_pend_r <= pc_hold_pend_nxt;
			abort_r        <= abort_nxt;
			pc_hold_r      <= pc_hold_nxt;
			lvl_chg_r      <= lvl_chg_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flops

	assign PRDATA_O       = prdata_r;
	assign PREADY_O       = pready_r;
	assign PSLVERR_O      = pslverr_r;
	assign ABORT_O        = abort_r;
	assign PC_HOLD_O      = pc_hold_r;
	assign LEVEL_CHANGE_O = lvl_chg_r;
	assign ACTIVE_LEVEL_O = level_r;
	assign PANEL_INT_O    = intsys_r;
endmodule

// file: testbench/iic_io_dev.sv
`timescale 1ns/1ns
module iic_io_dev (
	input  wire logic       clk_i,     // cpu clock
	input  wire logic       rst_n_i,   // async reset
	input  wire logic       start_i,   // transfer starts
	input  wire logic [7:0] delay_i,   // answer delay, 8'hFF absent
	output logic            connect_o  // response line
);
	logic [7:0] cnt;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 8'h00;
		end else if (start_i) begin
			cnt <= 8'h01;
		end else if (cnt != 8'h00 && cnt != 8'hFF) begin
			cnt <= cnt + 8'h01;
		end
	end

	// answer stands four cycles, then the line drops back to its idle low level
	assign connect_o = (delay_i != 8'hFF) && (cnt > delay_i) && (cnt <= delay_i + 8'h04);
endmodule

// file: testbench/iic_ctrl_assertions.sv
`timescale 1ns/1ns
module iic_ctrl_checker #(
	parameter int IO_TIMEOUT_CYC = 120
) (
	input wire logic        CORE_CLK_I,     // clock
	input wire logic        RESET_N_I,      // reset
	input wire logic        PSEL_I,         // select
	input wire logic        PENABLE_I,      // enable
	input wire logic [31:0] PRDATA_O,       // read data
	input wire logic        PREADY_O,       // ready
	input wire logic        PSLVERR_O,      // error
	input wire logic [1:0]  RING_I,         // ring
	input wire logic        ION_INSTR_I,    // on instr
	input wire logic        IOF_INSTR_I,    // off instr
	input wire logic        ABORT_O,        // abort
	input wire logic        PC_HOLD_O,      // pc hold
	input wire logic        LEVEL_CHANGE_O, // level switch
	input wire logic [3:0]  ACTIVE_LEVEL_O, // level
	input wire logic        PANEL_INT_O     // panel lamp
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	a_ready_access: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
		else $error("ready missing in access");
	a_ready_idle: assert property (!(PSEL_I && PENABLE_I) |-> !PREADY_O && PRDATA_O == 32'h0000_0000)
		else $error("bus answer outside access");
	a_err_ready: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0000_0000)
		else $error("error without empty answer");
	a_hold_abort: assert property (PC_HOLD_O |-> ABORT_O)
		else $error("pc hold without abort");
	a_abort_once: assert property (ABORT_O |=> !ABORT_O)
		else $error("second abort while cause locked");
	a_abort_on: assert property (ABORT_O |-> $past(PANEL_INT_O))
		else $error("abort with interrupt system off");
	a_ion_lights: assert property (ION_INSTR_I && RING_I >= 2'h2 |=> PANEL_INT_O)
		else $error("panel not lit");
	a_iof_darkens: assert property (IOF_INSTR_I && RING_I >= 2'h2 |=> !PANEL_INT_O)
		else $error("panel still lit");
	a_off_frozen: assert property (!PANEL_INT_O && !ION_INSTR_I |=> !LEVEL_CHANGE_O)
		else $error("level change while off");
	a_level_moves: assert property (!LEVEL_CHANGE_O |-> $stable(ACTIVE_LEVEL_O))
		else $error("level moved without change");
	a_change_moves: assert property (LEVEL_CHANGE_O |-> ACTIVE_LEVEL_O != $past(ACTIVE_LEVEL_O))
		else $error("level change without new level");
	a_reset_clear: assert property ($rose(RESET_N_I) |-> ACTIVE_LEVEL_O == 4'h0 && !PANEL_INT_O)
		else $error("not clear after reset");
endmodule

bind iic_ctrl iic_ctrl_checker #(.IO_TIMEOUT_CYC(IO_TIMEOUT_CYC)) i_iic_ctrl_checker (
	.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RING_I(RING_I),
	.ION_INSTR_I(ION_INSTR_I), .IOF_INSTR_I(IOF_INSTR_I), .ABORT_O(ABORT_O),
	.PC_HOLD_O(PC_HOLD_O), .LEVEL_CHANGE_O(LEVEL_CHANGE_O), .ACTIVE_LEVEL_O(ACTIVE_LEVEL_O),
	.PANEL_INT_O(PANEL_INT_O)
);

// file: testbench/tb.sv
`timescale 1ns/1ns
`include "iic_defs.svh"
module tb;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready;
	logic        fetch = 1'b0, supply = 1'b0, pslv, rerr, abort, hold, lchg, panel, conn;
	logic [1:0]  ring = 2'h2;
	logic [3:0]  level;
	logic [7:0]  paddr = 8'h00, dly = 8'h02;
	logic [13:0] finfo = 14'h1234;
	logic [14:0] ev = 15'h0000;
	logic [17:0] faddr = 18'h2_ABCD;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
	int          bad_count = 0, tests_run = 0, cycles = 0, n_abort = 0, n_hold = 0, n_chg = 0;
	int          t_ev[8] = '{0, 1, 2, 3, 4, 12, 13, 11};
	int          t_ring[8] = '{2, 2, 2, 1, 2, 1, 1, 2};
	int          t_fetch[8] = '{1, 1, 1, 0, 1, 0, 0, 0};
	int          t_code[8] = '{2, 3, 4, 6, 9, 6, 6, 7};
	int          t_hold[8] = '{1, 2, 2, 2, 3, 3, 3, 3};

	iic_ctrl #(.IO_TIMEOUT_CYC(8)) i_iic_ctrl (
		.CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslv), .INSTR_DONE_I(ev[14]), .FETCH_CYCLE_I(fetch), .RING_I(ring),
		.PRIV_INSTR_I(ev[3]), .ION_INSTR_I(ev[12]), .IOF_INSTR_I(ev[13]),
		.MONITOR_CALL_I(ev[10]), .PROTECT_VIOLATION_I(ev[0]), .PAGE_FAULT_I(ev[1]),
		.ILLEGAL_INSTR_I(ev[2]), .FLOAT_DIVIDE_ZERO_I(ev[6]), .EXECUTE_REG_NEST_I(ev[7]),
		.NORMALIZE_OP_OVF_I(ev[8]), .REG_DIVIDE_OVF_I(ev[9]), .IO_TRANSFER_START_I(ev[11]),
		.IO_CONNECT_I(conn), .PARITY_ERROR_I(ev[5]), .OUT_OF_RANGE_I(ev[4]),
		.FAULT_ADDR_I(faddr), .FAULT_INFO_I(finfo), .SUPPLY_LOSS_I(supply), .ABORT_O(abort),
		.PC_HOLD_O(hold), .LEVEL_CHANGE_O(lchg), .ACTIVE_LEVEL_O(level), .PANEL_INT_O(panel)
	);
	iic_io_dev i_iic_io_dev (
		.clk_i(clk), .rst_n_i(rst_n), .start_i(ev[11]), .delay_i(dly), .connect_o(conn)
	);

	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		n_abort <= n_abort + int'(abort === 1'b1);
		n_hold <= n_hold + int'(hold === 1'b1);
		n_chg <= n_chg + int'(lchg === 1'b1);
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// idle cycle at the end keeps each bus signal to one assignment per time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		tick(1);
		pen <= 1'b1;
		tick(1);
		while (pready !== 1'b1) tick(1);
		rdata = prdata;
		rerr = pslv;
		psel <= 1'b0;
		pen <= 1'b0;
		tick(1);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rdata);
	endtask
	task automatic rc(input logic [3:0] e);
		rdc("cause", `IIC_OFF_CAUSE, 32'(e));
	endtask
	task automatic lv(input logic [3:0] e);
		chk("level", 32'(e), 32'(level));
	endtask
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		tick(1);
		ev[i] <= 1'b0;
		tick(1);
	endtask
	// level 0 needs its own request bit, otherwise the level stays where it is
	task automatic leave;
		apb(1'b1, `IIC_OFF_LEVEL_REQ, 32'h0000_0001);
		pulse(14);
		tick(2);
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(10);
		rst_n <= 1'b1;
		apb(1'b1, `IIC_OFF_CUR_LEVEL, 32'h0000_000F);
		rdc("req", `IIC_OFF_LEVEL_REQ, 32'h0000_0000);
		rdc("en", `IIC_OFF_LEVEL_EN, 32'h0000_0000);
		rdc("cur", `IIC_OFF_CUR_LEVEL, 32'h0000_0000);
		rdc("ctrl", `IIC_OFF_CTRL, 32'h0000_000C);
		rdc("unmapped", 8'h40, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, 32'(rerr));
		rc(4'h0);
		rdc("faddr", `IIC_OFF_FAULT_ADDR, 32'h0000_0000);
		rdc("ctrl", `IIC_OFF_CTRL, 32'h0000_0000);
		apb(1'b1, `IIC_OFF_LEVEL_EN, 32'h0000_4001);
		rdc("en", `IIC_OFF_LEVEL_EN, 32'h0000_4001);
		apb(1'b1, `IIC_OFF_SRC_MASK, 32'hFFFF_FFF7);
		rdc("mask", `IIC_OFF_SRC_MASK, 32'h0000_FFF7);
		pulse(12);
		chk("panel", 32'h0000_0001, 32'(panel));
		pulse(1);
		tick(20);
		chk("aborts", 32'h0000_0000, 32'(n_abort));
		apb(1'b1, `IIC_OFF_CTRL, 32'h0000_0001);
		pulse(1);
		tick(20);
		chk("aborts", 32'h0000_0000, 32'(n_abort));
		apb(1'b1, `IIC_OFF_SRC_MASK, 32'h0000_FFFF);
		dly <= 8'hFF;
		for (int k = 0; k < 8; k++) begin
			ring <= 2'(t_ring[k]);
			fetch <= t_fetch[k][0];
			pulse(t_ev[k]);
			tick(20);
			chk("aborts", 32'(k + 1), 32'(n_abort));
			chk("holds", 32'(t_hold[k]), 32'(n_hold));
			lv(4'hE);
			rc(4'(t_code[k]));
		end
		ring <= 2'h2;
		fetch <= 1'b0;
		chk("changes", 32'h0000_0001, 32'(n_chg));
		chk("panel", 32'h0000_0001, 32'(panel));
		rdc("fstat", `IIC_OFF_FAULT_STAT, 32'h0000_48D2);
		rdc("faddr", `IIC_OFF_FAULT_ADDR, 32'h0000_ABCD);
		dly <= 8'h02;
		pulse(11);
		tick(20);
		chk("aborts", 32'h0000_0008, 32'(n_abort));
		pulse(0);
		pulse(2);
		tick(20);
		chk("aborts", 32'h0000_0009, 32'(n_abort));
		rc(4'h2);
		tick(20);
		rc(4'h4);
		leave();
		lv(4'h0);
		for (int k = 6; k < 10; k++) begin
			pulse(k);
			rdc("errind", `IIC_OFF_ERR_IND, 32'h0000_0001);
			pulse(14);
			tick(2);
			lv(4'hE);
			rc(4'h5);
			if (k == 6) begin
				leave();
				pulse(14);
				tick(2);
				lv(4'hE);
				rc(4'h5);
			end
			apb(1'b1, `IIC_OFF_ERR_IND, 32'h0000_0000);
			leave();
			lv(4'h0);
		end
		pulse(10);
		pulse(14);
		tick(2);
		rc(4'h1);
		leave();
		faddr <= 18'h1_2345;
		finfo <= 14'h0ABC;
		pulse(5);
		tick(4);
		lv(4'h0);
		pulse(14);
		tick(2);
		lv(4'hE);
		rc(4'h8);
		rdc("fstat", `IIC_OFF_FAULT_STAT, 32'h0000_2AF1);
		rdc("faddr", `IIC_OFF_FAULT_ADDR, 32'h0000_2345);
		leave();
		supply <= 1'b1;
		pulse(5);
		tick(4);
		pulse(14);
		tick(2);
		rc(4'hA);
		pulse(13);
		chk("panel", 32'h0000_0000, 32'(panel));
		lv(4'hE);
		final_report();
	end
endmodule
